/* pwo_consts.svh */
// Constants for the pulse-width output generator.
// Assumes inclusion by the package and the design modules of this block.
`ifndef PWO_CONSTS_SVH
`define PWO_CONSTS_SVH
`define PWO_CNT_W 8
`define PWO_CNT_MAX 8'hfe
`define PWO_CMP_ALWAYS_LOW 8'hff
`define PWO_CMP_ALWAYS_HIGH 8'h00
`define PWO_PRESCALE_RST 8'h00
`define PWO_COMPARE_RST 8'h00
`define PWO_VECTOR 11'h033
`define PWO_SRC_W 7
`define PWO_SRC_EXT_A 0
`define PWO_SRC_TIMER0 1
`define PWO_SRC_EXT_B 2
`define PWO_SRC_PWO 3
`define PWO_SRC_TIMER_I 4
`define PWO_SRC_SERIAL 5
`define PWO_SRC_ADC 6
`define PWO_VEC_EXT_A 11'h003
`define PWO_VEC_TIMER0 11'h00b
`define PWO_VEC_EXT_B 11'h013
`define PWO_VEC_TIMER_I 11'h01b
`define PWO_VEC_SERIAL 11'h023
`define PWO_VEC_ADC 11'h02b
`define PWO_POWER_CONTROL_REG_IDLE 0
`define PWO_POWER_CONTROL_REG_PD 1
`endif

/* pwo_gen.sv */
// Pulse-width output generator with prescaler, counter and pin mux.
// Assumes configuration comes from the CPU's special function registers.
// Summary of operation
// - Dedicated 8-bit prescaler sets the rate.
// - Prescaler and counter serve only this block.
// - Counter runs 0 to 254 then wraps.
// - Output goes high on compare match.
// - Output goes low at counter wrap.
// - Compare 0 always high, 255 always low.
// - Duty programmable in 1/255 steps.
// - Enabled: pin driven with strong pull-up.
// - Disabled: pin is port I/O, counter runs.
// - Idle mode stops the generator.
// - Port pins keep latched data except output.
// - Overflow priority between ext_b and timer_i.
// - Overflow vector at location 033.
// - Disabled in reset until software enables.
// - Output high in idle/power-down; counter halts.
// - Unmasked overflow raises an interrupt.
// - Rate is fosc over (1+prescale)255.
`include "pwo_consts.svh"
module pwo_gen import pwo_pkg::*; #(
  parameter int CNT_W = `PWO_CNT_W
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire pwo_cfg_s i_cfg,
  input wire logic [1:0] i_power_control_reg,
  input wire logic i_port_latch,
  input wire logic i_irq_mask_en,
  input wire logic i_global_en,
  input wire logic [`PWO_SRC_W-1:0] i_other_req,
  input wire logic i_irq_ack,
  output pwo_pin_s o_shared_output_pin,
  output logic o_ovf_flag,
  output logic o_irq,
  output logic [10:0] o_vector,
  output logic [CNT_W-1:0] o_count
);
  // ==========================================================
  // Mode decode
  pwo_mode_e mode;
  assign mode = i_power_control_reg[`PWO_POWER_CONTROL_REG_PD] ? PWO_PDOWN :
                i_power_control_reg[`PWO_POWER_CONTROL_REG_IDLE] ? PWO_IDLE : PWO_RUN;
  wire run = i_ce && (mode == PWO_RUN);

  // ==========================================================
  // Prescaler and counter
  logic [7:0] pre_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] cmp_ff;
  logic wave_ff;
  logic ovf_ff;
  logic en_ff;
  wire pre_zero = (pre_ff == 8'h00);
  wire step = run && pre_zero;
  wire wrap = step && (cnt_ff == CNT_W'(`PWO_CNT_MAX));
  wire [CNT_W-1:0] nxt_cnt = wrap ? '0 : cnt_ff + CNT_W'(1);
  wire [CNT_W-1:0] cmp_use = wrap ? CNT_W'(i_cfg.compare) : cmp_ff;
  wire [CNT_W-1:0] cnt_view = wrap ? '0 : nxt_cnt;
  // Comparator on the new count: set wins over the reset at zero, so 0 is high.
  wire hit = (cnt_view == cmp_use);
  wire nxt_wave = hit ? 1'b1 : (wrap ? 1'b0 : wave_ff);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pre_ff <= `PWO_PRESCALE_RST;
      cnt_ff <= '0;
    end else if (run) begin
      pre_ff <= pre_zero ? i_cfg.rate_prescaler_reg : pre_ff - 8'h01;
      if (step) cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cmp_ff <= CNT_W'(`PWO_COMPARE_RST);
      wave_ff <= 1'b0;
    end else if (step) begin
      if (wrap) cmp_ff <= CNT_W'(i_cfg.compare);
      wave_ff <= nxt_wave;
    end
  end

  // ==========================================================
  // Enable and overflow flag
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      en_ff <= 1'b0;
    end else if (i_ce) begin
      en_ff <= i_cfg.output_enable_reg;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ovf_ff <= 1'b0;
    end else if (i_ce) begin
      // Set wins over acknowledge so an overflow in the ack cycle stays.
      ovf_ff <= wrap | (ovf_ff & ~i_irq_ack);
    end
  end

  // ==========================================================
  // Pin mux
  wire low_power = (mode != PWO_RUN);
  wire pin_wave = low_power ? 1'b1 : wave_ff;
  assign o_shared_output_pin.out = en_ff ? pin_wave : i_port_latch;
  // Quasi-bidirectional port: only drive when enabled or the latch holds 0.
  assign o_shared_output_pin.oe = en_ff | ~i_port_latch;
  assign o_ovf_flag = ovf_ff;
  assign o_count = cnt_ff;

  // ==========================================================
  // Interrupt priority
  logic [`PWO_SRC_W-1:0] reqs;
  always_comb begin
    reqs = i_other_req;
    reqs[`PWO_SRC_PWO] = ovf_ff & i_irq_mask_en;
  end
  pwo_irq_prio u_prio (
    .i_req(reqs),
    .i_global_en(i_global_en),
    .o_irq(o_irq),
    .o_vector(o_vector)
  );

  // ==========================================================
  // Checks
  // The properties watch the registers as well as the pin, so a fault in the pin mux
  // and a fault in the counter show up as separate failures.
  sequence s_wrap;
    wrap;
  endsequence
  sequence s_step;
    step;
  endsequence
  sequence s_mid_step;
    step && !wrap;
  endsequence
  sequence s_match;
    step && hit;
  endsequence
  sequence s_zero_load;
    wrap && i_cfg.compare == `PWO_CMP_ALWAYS_HIGH;
  endsequence
  sequence s_frozen;
    !i_ce;
  endsequence
  sequence s_low_power;
    mode != PWO_RUN;
  endsequence
  sequence s_ack_quiet;
    i_ce && i_irq_ack && !wrap;
  endsequence
  sequence s_pre_count;
    run && !pre_zero;
  endsequence
  sequence s_pre_load;
    run && pre_zero;
  endsequence

  // ==========================================================
  // Counter checks
  a_count_range: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cnt_ff <= CNT_W'(`PWO_CNT_MAX))
    else $error("count past 254");
  a_wrap_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_wrap
    |=> cnt_ff == '0)
    else $error("no wrap to zero");
  a_step_count: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_mid_step
    |=> cnt_ff == $past(cnt_ff) + CNT_W'(1))
    else $error("count did not step by one");
  a_pre_down: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_pre_count
    |=> pre_ff == $past(pre_ff) - 8'h01)
    else $error("prescaler did not count down");
  a_pre_reload: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_pre_load
    |=> pre_ff == $past(i_cfg.rate_prescaler_reg))
    else $error("prescaler did not reload");
  a_no_step_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !step
    |=> cnt_ff == $past(cnt_ff))
    else $error("count moved without a step");
  a_idle_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_low_power
    |=> cnt_ff == $past(cnt_ff))
    else $error("counter ran");
  a_pdown_freeze: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    mode == PWO_PDOWN
    |=> $stable(cnt_ff) && $stable(pre_ff))
    else $error("counter ran in power-down");
  // A low enable must hold every register, the flag included, or a paused core
  // would see a spurious overflow when it resumes.
  a_ce_freeze: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_frozen
    |=> $stable(pre_ff) && $stable(cnt_ff) && $stable(cmp_ff)
        && $stable(wave_ff) && $stable(ovf_ff)
        && $stable(en_ff))
    else $error("state moved with enable low");

  // ==========================================================
  // Waveform checks
  a_match_high: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_match
    |=> wave_ff)
    else $error("match not high");
  a_wrap_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wrap && i_cfg.compare != 8'h00
    |=> !wave_ff)
    else $error("wrap not low");
  a_wave_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !step
    |=> wave_ff == $past(wave_ff))
    else $error("wave moved between steps");
  a_rise_at_cmp: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(wave_ff)
    |-> cnt_ff == cmp_ff)
    else $error("wave rose off the compare value");
  a_fall_at_wrap: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(wave_ff)
    |-> cnt_ff == '0)
    else $error("wave fell away from zero");
  a_zero_high: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_zero_load
    |=> wave_ff)
    else $error("compare zero not high");
  a_max_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    step && cmp_use == CNT_W'(`PWO_CMP_ALWAYS_LOW)
    |=> !wave_ff)
    else $error("compare 255 not low");
  a_cmp_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_mid_step
    |=> cmp_ff == $past(cmp_ff))
    else $error("compare moved");
  a_cmp_take: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_wrap
    |=> cmp_ff == CNT_W'($past(i_cfg.compare)))
    else $error("compare not taken at wrap");

  // ==========================================================
  // Pin checks
  a_pin_drive: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    en_ff
    |-> o_shared_output_pin.oe)
    else $error("pin not driven");
  a_pin_wave: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    en_ff && mode == PWO_RUN
    |-> o_shared_output_pin.out == wave_ff)
    else $error("pin does not carry the wave");
  a_pin_port: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !en_ff
    |-> o_shared_output_pin.out == i_port_latch && o_shared_output_pin.oe == !i_port_latch)
    else $error("pin not ordinary port");
  a_port_keep: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !en_ff && mode != PWO_RUN
    |-> o_shared_output_pin.out == i_port_latch)
    else $error("port data lost in low power");
  a_lowpwr_high: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    en_ff && mode != PWO_RUN
    |-> o_shared_output_pin.out)
    else $error("not high");
  a_en_follow: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce
    |=> en_ff == $past(i_cfg.output_enable_reg))
    else $error("enable did not follow its bit");
  a_reset_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(i_rst)
    |-> !en_ff)
    else $error("enabled straight out of reset");

  // ==========================================================
  // Interrupt checks
  a_ovf_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && wrap
    |=> ovf_ff)
    else $error("overflow lost");
  a_ovf_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ovf_ff && i_ce && !i_irq_ack
    |=> ovf_ff)
    else $error("flag dropped without ack");
  a_ovf_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_ack_quiet
    |=> !ovf_ff)
    else $error("ack did not clear the flag");
  a_ovf_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && !wrap && !ovf_ff
    |=> !ovf_ff)
    else $error("flag set without overflow");
  a_req_mask: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_irq_mask_en
    |-> !reqs[`PWO_SRC_PWO])
    else $error("masked overflow requested");
  a_irq_raise: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_global_en && i_irq_mask_en && ovf_ff
    |-> o_irq)
    else $error("overflow not requested");
  a_gate_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_global_en
    |-> !o_irq && o_vector == 11'h000)
    else $error("request with global enable low");
  a_prio_ext_b: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_global_en && reqs[`PWO_SRC_EXT_B] && reqs[1:0] == 2'h0
    |-> o_vector == `PWO_VEC_EXT_B)
    else $error("second external request not first");
  a_vector: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_global_en && reqs[`PWO_SRC_PWO] && reqs[2:0] == 3'h0
    |-> o_vector == `PWO_VECTOR)
    else $error("bad vector");
endmodule : pwo_gen

/* pwo_irq_prio.sv */
// Fixed single-level interrupt priority resolver.
// Assumes request levels are held by their sources until serviced.
`include "pwo_consts.svh"
module pwo_irq_prio import pwo_pkg::*; (
  input wire logic [`PWO_SRC_W-1:0] i_req,
  input wire logic i_global_en,
  output logic o_irq,
  output logic [10:0] o_vector
);
  // ==========================================================
  // Priority select
  wire [`PWO_SRC_W-1:0] req_ok = i_global_en ? i_req : '0;
  assign o_irq = |req_ok;
  always_comb begin
    o_vector = 11'h000;
    // Lowest first so the highest active source overwrites.
    if (req_ok[`PWO_SRC_ADC]) o_vector = `PWO_VEC_ADC;
    if (req_ok[`PWO_SRC_SERIAL]) o_vector = `PWO_VEC_SERIAL;
    if (req_ok[`PWO_SRC_TIMER_I]) o_vector = `PWO_VEC_TIMER_I;
    if (req_ok[`PWO_SRC_PWO]) o_vector = `PWO_VECTOR;
    if (req_ok[`PWO_SRC_EXT_B]) o_vector = `PWO_VEC_EXT_B;
    if (req_ok[`PWO_SRC_TIMER0]) o_vector = `PWO_VEC_TIMER0;
    if (req_ok[`PWO_SRC_EXT_A]) o_vector = `PWO_VEC_EXT_A;
  end
endmodule : pwo_irq_prio

/* pwo_load_model.sv */
// Load on the shared output pin: resolves the level seen on the wire.
// Assumes the port pin has an internal pull-up when nobody drives it.
module pwo_load_model import pwo_pkg::*; (
  input wire pwo_pin_s i_pin,
  output logic o_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // A released pin floats up, so a stuck driver shows as a low level.
  assign o_level = i_pin.oe ? i_pin.out : 1'b1;
endmodule : pwo_load_model

/* pwo_pkg.sv */
// Types for the pulse-width output generator.
// Assumes the constants header is on the include path.
`include "pwo_consts.svh"
package pwo_pkg;
  typedef struct packed {
    logic [7:0] rate_prescaler_reg;
    logic [7:0] compare;
    logic output_enable_reg;
  } pwo_cfg_s;
  typedef struct packed {
    logic out;
    logic oe;
  } pwo_pin_s;
  typedef enum logic [1:0] {PWO_RUN, PWO_IDLE, PWO_PDOWN} pwo_mode_e;
endpackage : pwo_pkg

/* tb.sv */
// Self-checking bench for the pulse-width output generator.
// Assumes the package, the constants header and the load model come first.
module tb import pwo_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_sys_clk = 1'b0;
  logic rst = 1'b1, ack = 1'b0, latch = 1'b1, msk = 1'b0, ce = 1'b1, lvl, flag, irq;
  logic [1:0] power_control_reg = 2'h0;
  logic [6:0] oreq = 7'h00;
  logic [10:0] vec;
  logic [7:0] cnt, cur, hold, last = 8'h00;
  logic [7:0] tbl [4] = '{8'h00, 8'h01, 8'hfe, 8'hff};
  pwo_cfg_s cfg = '0;
  pwo_pin_s pin;
  int miscompares = 0, samples_checked = 0, cyc = 0, hi = 0, len = 0, wraps = 0, p;
  int note_q [$];
  pwo_gen i_dut (.i_sys_clk(i_sys_clk), .i_rst(rst), .i_ce(ce), .i_cfg(cfg),
    .i_power_control_reg(power_control_reg), .i_port_latch(latch), .i_irq_mask_en(msk),
    .i_global_en(msk), .i_other_req(oreq), .i_irq_ack(ack), .o_shared_output_pin(pin),
    .o_ovf_flag(flag), .o_irq(irq), .o_vector(vec), .o_count(cnt));
  pwo_load_model i_load (.i_pin(pin), .o_level(lvl));
  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask : done
  task automatic wait_wrap();
    int w;
    w = wraps;
    while (wraps == w) @(negedge i_sys_clk);
  endtask : wait_wrap
  // The new compare lands mid-period, so the noted period still uses the old one.
  task automatic period(input int h, input logic [7:0] c);
    wait_wrap();
    note_q.push_back(h);
    note_q.push_back(255 * (p + 1));
    repeat (5) @(negedge i_sys_clk);
    cfg.compare = c;
  endtask : period
  // ==========================================================
  // Clock, timeout and period monitor
  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    if (++cyc > 20000) begin
      miscompares++;
      close_out();
    end
  end
  // Sampled just after the edge so the registered outputs have settled.
  always @(posedge i_sys_clk) begin
    #1;
    if (cnt == 8'h00 && last != 8'h00) begin
      wraps++;
      if (note_q.size() > 1) begin
        check(hi, note_q.pop_front(), "high time");
        check(len, note_q.pop_front(), "period");
      end
      hi = 0;
      len = 0;
    end
    hi += int'(lvl);
    len++;
    last = cnt;
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(95));
    p = $urandom_range(2, 0);
    cur = 8'($urandom_range(254, 1));
    cfg.output_enable_reg = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    check(cnt, 8'h00, "reset count");
    check(lvl, 1'b1, "reset pin");
    rst = 1'b0;
    cfg = '{rate_prescaler_reg: 8'(p), compare: cur, output_enable_reg: 1'b1};
    done("reset");
    wait_wrap();
    foreach (tbl[i]) begin
      period((255 - cur) * (p + 1), tbl[i]);
      cur = tbl[i];
    end
    period(0, cur);
    wait_wrap();
    done("duty");
    for (int m = 1; m < 3; m++) begin
      power_control_reg = 2'(m);
      repeat (3) @(negedge i_sys_clk);
      hold = cnt;
      repeat (20) @(negedge i_sys_clk);
      check(cnt, hold, "count halted");
      check(lvl, 1'b1, "pin high");
    end
    power_control_reg = 2'h0;
    ce = 1'b0;
    hold = cnt;
    repeat (20) @(negedge i_sys_clk);
    check(cnt, hold, "enable freeze");
    ce = 1'b1;
    done("power");
    cfg.output_enable_reg = 1'b0;
    latch = 1'b1;
    period(255 * (p + 1), cur);
    wait_wrap();
    done("port");
    check(irq, 1'b0, "masked");
    msk = 1'b1;
    wait_wrap();
    repeat (2) @(negedge i_sys_clk);
    check(flag, 1'b1, "flag");
    check(irq, 1'b1, "raised");
    check(vec, 11'h033, "vector");
    oreq = 7'h04;
    @(negedge i_sys_clk);
    check(vec, 11'h013, "ext b first");
    oreq = 7'h10;
    @(negedge i_sys_clk);
    check(vec, 11'h033, "above timer");
    oreq = 7'h00;
    ack = 1'b1;
    @(negedge i_sys_clk);
    ack = 1'b0;
    @(negedge i_sys_clk);
    check(irq, 1'b0, "cleared");
    done("irq");
    close_out();
  end
endmodule : tb
